// ==== logic/dbcs_sequencer.sv ====
// Charge sequencer: wake-up and controlled charging, alarms, alert, servo
`timescale 1ns/1ps
module dbcs_sequencer
	import dbcs_pkg::*;
#(
	parameter logic [24:0] POLL_CYCLES = DBCS_POLL_CYCLES,
	parameter logic [7:0]  LIMIT_POLLS = DBCS_LIMIT_POLLS
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             ce,
	input  wire logic [3:0]       s_awaddr,
	input  wire logic             s_awvalid,
	output logic                  s_awready,
	input  wire logic [31:0]      s_wdata,
	input  wire logic [3:0]       s_wstrb,
	input  wire logic             s_wvalid,
	output logic                  s_wready,
	output logic [1:0]            s_bresp,
	output logic                  s_bvalid,
	input  wire logic             s_bready,
	input  wire logic [3:0]       s_araddr,
	input  wire logic             s_arvalid,
	output logic                  s_arready,
	output logic [31:0]           s_rdata,
	output logic [1:0]            s_rresp,
	output logic                  s_rvalid,
	input  wire logic             s_rready,
	input  dbcs_band_t [1:0]      band,
	input  dbcs_poll_t [1:0]      poll_rsp,
	input  wire logic             adapter_present,
	input  wire logic             adapter_divider_input,
	input  wire logic             mode_pin_low,
	input  wire logic             bus_supply_sense,
	input  wire logic [2:0]       bus_line_low,
	input  wire logic             ara_addr_sent,
	input  wire logic             host_status_read,
	output logic                  poll_req,
	output logic [1:0]            wake_en,
	output logic [1:0]            ctrl_en,
	output logic [15:0]           prog_current,
	output logic                  low_current_mode,
	output logic                  vceil_bypass,
	output logic                  alert_oe,
	output logic [7:0]            ara_address
);

	logic [24:0] poll_cnt_ff;
	logic [24:0] stuck_cnt_ff;
	logic        poll_req_ff;
	logic        alert_ff;
	logic        adapter_ff;
	logic [1:0]  present_ff;
	logic [1:0]  wake_need_ff;
	logic [1:0]  alarm_ff;
	logic [1:0]  good_ff;
	logic [1:0]  timed_out;
	logic [1:0]  noack_out;
	logic [1:0]  wake_ff;
	logic [1:0]  ctrl_ff;
	logic        hold_ff;
	logic [15:0] prog_ff;
	logic        low_mode_ff;
	logic [15:0] rcur_ff [2];
	logic [15:0] cur_ff  [2];
	logic [2:0]  ctrl_reg_ff;
	logic        restart_ff;
	logic [15:0] wake_cur_ff;
	logic        aw_have_ff;
	logic        w_have_ff;
	logic [3:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        awready_ff;
	logic        wready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	logic        poll_tick;
	logic        bus_stuck;
	logic        common_ok;
	logic [1:0]  present;
	logic [1:0]  band_ok;
	logic [1:0]  wake_ok;
	logic [1:0]  ctrl_ok;
	logic [1:0]  nxt_wake;
	logic [1:0]  nxt_ctrl;
	logic        stop_all;
	logic        alert_set;
	logic        wr_fire;
	logic [31:0] wmask;
	logic [17:0] diff [2];
	logic [17:0] step;
	logic [17:0] nxt_sum;

	assign s_awready        = awready_ff;
	assign s_wready         = wready_ff;
	assign s_bvalid         = bvalid_ff;
	assign s_bresp          = bresp_ff;
	assign s_arready        = arready_ff;
	assign s_rvalid         = rvalid_ff;
	assign s_rdata          = rdata_ff;
	assign s_rresp          = rresp_ff;
	assign poll_req         = poll_req_ff;
	assign wake_en          = wake_ff;
	assign ctrl_en          = ctrl_ff;
	assign prog_current     = prog_ff;
	assign low_current_mode = low_mode_ff;
	assign vceil_bypass     = low_mode_ff;
	assign alert_oe         = alert_ff;

	// Poll interval timer, free running on the system clock while ce is high
	assign poll_tick = (poll_cnt_ff == POLL_CYCLES - 25'h0000001);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			poll_cnt_ff <= 25'h0000000;
			poll_req_ff <= 1'b0;
		end else if (ce) begin
			poll_cnt_ff <= poll_tick ? 25'h0000000 : poll_cnt_ff + 25'h0000001;
			poll_req_ff <= poll_tick;
		end
	end

	// Any bus line low past one poll interval counts as a grounded bus
	assign bus_stuck = (stuck_cnt_ff >= POLL_CYCLES);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			stuck_cnt_ff <= 25'h0000000;
		end else if (ce) begin
			if (bus_line_low == 3'h0)
				stuck_cnt_ff <= 25'h0000000;
			else if (!bus_stuck)
				stuck_cnt_ff <= stuck_cnt_ff + 25'h0000001;
		end
	end

	assign common_ok = adapter_present && !ctrl_reg_ff[DBCS_CTRL_INHIBIT] &&
		!(mode_pin_low && bus_supply_sense) && !ctrl_reg_ff[DBCS_CTRL_CALIB] &&
		!ctrl_reg_ff[DBCS_CTRL_PNG] && adapter_divider_input && !bus_stuck;

	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_bat
			logic [7:0] chg_polls_ff;
			logic [7:0] noack_polls_ff;
			logic       any_ack;
			logic       cur_ans;
			logic       cold_under;

			assign present[b] = (band[b] != BAND_OVER);
			assign band_ok[b] = (band[b] == BAND_COLD) ||
				(band[b] == BAND_IDEAL) || (band[b] == BAND_UNDER);
			assign cold_under = (band[b] == BAND_COLD) || (band[b] == BAND_UNDER);
			assign any_ack = poll_rsp[b].alarm_ack || cur_ans;
			assign cur_ans = poll_rsp[b].rcur_ack || poll_rsp[b].cur_ack ||
				poll_rsp[b].rvol_ack || poll_rsp[b].vol_ack;
			assign timed_out[b] = cold_under && (chg_polls_ff >= LIMIT_POLLS);
			assign noack_out[b] = (noack_polls_ff >= LIMIT_POLLS);

			// Charge time, counted in poll ticks while this battery charges
			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					chg_polls_ff <= 8'h00;
				end else if (ce) begin
					if (!present[b] || restart_ff)
						chg_polls_ff <= 8'h00;
					else if (poll_tick && (wake_ff[b] || ctrl_ff[b]) &&
						chg_polls_ff != 8'hFF)
						chg_polls_ff <= chg_polls_ff + 8'h01;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					noack_polls_ff <= 8'h00;
				end else if (ce) begin
					if (!present[b] || (poll_rsp[b].done && any_ack))
						noack_polls_ff <= 8'h00;
					else if (poll_tick && noack_polls_ff != 8'hFF)
						noack_polls_ff <= noack_polls_ff + 8'h01;
				end
			end

			// Reset leaves the need set, so power-on retries both batteries
			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					wake_need_ff[b] <= 1'b1;
				end else if (ce) begin
					if (restart_ff || (present[b] && !present_ff[b]))
						wake_need_ff[b] <= 1'b1;
					else if (!present[b] || (poll_rsp[b].done && cur_ans))
						wake_need_ff[b] <= 1'b0;
					else if (poll_rsp[b].done && !any_ack && !wake_ff[b] &&
						!ctrl_ff[b] && band[b] == BAND_IDEAL)
						wake_need_ff[b] <= 1'b1;
				end
			end

			// Set from the alarm word lands after the clears, so it wins
			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					alarm_ff[b] <= 1'b0;
				end else if (ce) begin
					if (!present[b] || restart_ff)
						alarm_ff[b] <= 1'b0;
					if (poll_rsp[b].done && poll_rsp[b].alarm_ack)
						alarm_ff[b] <= (poll_rsp[b].alarm[15:12] != 4'h0);
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					good_ff[b]  <= 1'b0;
					rcur_ff[b]  <= 16'h0000;
					cur_ff[b]   <= 16'h0000;
					present_ff[b] <= 1'b0;
				end else if (ce) begin
					present_ff[b] <= present[b];
					if (!present[b]) begin
						good_ff[b] <= 1'b0;
					end else if (poll_rsp[b].done) begin
						good_ff[b] <= poll_rsp[b].alarm_ack &&
							poll_rsp[b].alarm[15:12] == 4'h0 &&
							poll_rsp[b].rvol_ack && poll_rsp[b].rvol != 16'h0000 &&
							poll_rsp[b].vol_ack && poll_rsp[b].rcur_ack &&
							poll_rsp[b].rcur != 16'h0000 && poll_rsp[b].cur_ack;
						rcur_ff[b] <= poll_rsp[b].rcur;
						cur_ff[b]  <= poll_rsp[b].cur;
					end
				end
			end

			assign wake_ok[b] = wake_need_ff[b] && present[b] && band_ok[b] &&
				common_ok && !alarm_ff[b] && !timed_out[b];
			assign ctrl_ok[b] = present[b] && band_ok[b] && common_ok &&
				good_ff[b] && !alarm_ff[b] && !noack_out[b];
			assign diff[b] = {2'h0, rcur_ff[b]} - {2'h0, cur_ff[b]};

			alarm_cache_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
				ce && present[b] && !restart_ff && poll_rsp[b].done &&
				poll_rsp[b].alarm_ack && poll_rsp[b].alarm[15:12] != 4'h0
				|=> alarm_ff[b] ##1 (!ctrl_ff[b] && wake_ff[b] == 1'b0))
				else $error("charge alarm not cached or charging went on");
		end
	endgenerate

	// Battery one keeps the wake slot; two waits until one cannot use it
	always_comb begin
		nxt_wake = 2'h0;
		if (wake_ok[0])
			nxt_wake = 2'h1;
		else if (wake_ok[1])
			nxt_wake = 2'h2;
	end

	assign stop_all = ((ctrl_ff & ~ctrl_ok) != 2'h0) || (nxt_wake != 2'h0);

	always_comb begin
		nxt_ctrl = 2'h0;
		if (!stop_all && !hold_ff)
			nxt_ctrl = ctrl_ok & ~wake_need_ff;
	end

	// After a stop, wait for the next poll tick; the decision then uses data from before that poll's answers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			hold_ff <= 1'b0;
		end else if (ce) begin
			if ((ctrl_ff & ~ctrl_ok) != 2'h0)
				hold_ff <= 1'b1;
			else if (poll_tick)
				hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wake_ff  <= 2'h0;
			ctrl_ff  <= 2'h0;
		end else if (ce) begin
			wake_ff <= nxt_wake;
			ctrl_ff <= nxt_ctrl;
		end
	end

	// A battery drawing more than asked pulls the step negative
	always_comb begin
		step = 18'h00000;
		if (ctrl_ff == 2'h3)
			step = ($signed(diff[0]) < $signed(diff[1])) ? diff[0] : diff[1];
		else if (ctrl_ff[0])
			step = diff[0];
		else if (ctrl_ff[1])
			step = diff[1];
	end

	assign nxt_sum = {2'h0, prog_ff} + step;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prog_ff     <= 16'h0000;
			low_mode_ff <= 1'b0;
		end else if (ce) begin
			low_mode_ff <= (nxt_wake != 2'h0);
			if (nxt_wake != 2'h0)
				prog_ff <= wake_cur_ff;
			else if (nxt_ctrl == 2'h0)
				prog_ff <= 16'h0000;
			else if (poll_tick)
				prog_ff <= nxt_sum[17] ? 16'h0000 :
					(nxt_sum[16] ? 16'hFFFF : nxt_sum[15:0]);
		end
	end

	// Set wins over a release arriving in the same cycle
	assign alert_set = (present != present_ff) || (adapter_present != adapter_ff);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			alert_ff    <= 1'b1;
			adapter_ff  <= 1'b0;
			ara_address <= DBCS_ARA_ADDR;
		end else if (ce) begin
			adapter_ff  <= adapter_present;
			ara_address <= DBCS_ARA_ADDR;
			if (alert_set)
				alert_ff <= 1'b1;
			else if (ara_addr_sent || host_status_read)
				alert_ff <= 1'b0;
		end
	end

	// AXI4-Lite write: address and data taken in either order
	assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
	assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
		{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= DBCS_RESP_OKAY;
			awaddr_ff  <= 4'h0;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
		end else if (ce) begin
			if (s_awvalid && awready_ff) begin
				aw_have_ff <= 1'b1;
				awready_ff <= 1'b0;
				awaddr_ff  <= s_awaddr;
			end
			if (s_wvalid && wready_ff) begin
				w_have_ff <= 1'b1;
				wready_ff <= 1'b0;
				wdata_ff  <= s_wdata;
				wstrb_ff  <= s_wstrb;
			end
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= (awaddr_ff == DBCS_OFF_CTRL ||
					awaddr_ff == DBCS_OFF_WAKE_CUR) ? DBCS_RESP_OKAY : DBCS_RESP_SLVERR;
			end
			if (bvalid_ff && s_bready) begin
				bvalid_ff  <= 1'b0;
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// Restart is a one-cycle pulse; the register never stores it
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl_reg_ff <= DBCS_CTRL_RST;
			restart_ff  <= 1'b0;
			wake_cur_ff <= DBCS_WAKE_CUR_RST;
		end else if (ce) begin
			restart_ff <= wr_fire && awaddr_ff == DBCS_OFF_CTRL &&
				wstrb_ff[0] && wdata_ff[DBCS_CTRL_RESTART];
			if (wr_fire && awaddr_ff == DBCS_OFF_CTRL && wstrb_ff[0])
				ctrl_reg_ff <= wdata_ff[2:0];
			if (wr_fire && awaddr_ff == DBCS_OFF_WAKE_CUR)
				wake_cur_ff <= (wake_cur_ff & ~wmask[15:0]) |
					(wdata_ff[15:0] & wmask[15:0]);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= DBCS_RESP_OKAY;
		end else if (ce) begin
			if (s_arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rresp_ff   <= DBCS_RESP_OKAY;
				unique case (s_araddr)
					DBCS_OFF_CTRL:     rdata_ff <= {29'h0, ctrl_reg_ff};
					DBCS_OFF_STATUS:   rdata_ff <= {23'h0, alert_ff, alarm_ff,
						wake_need_ff, ctrl_ff, wake_ff};
					DBCS_OFF_PROG:     rdata_ff <= {16'h0, prog_ff};
					DBCS_OFF_WAKE_CUR: rdata_ff <= {16'h0, wake_cur_ff};
					default: begin
						rdata_ff <= 32'h00000000;
						rresp_ff <= DBCS_RESP_SLVERR;
					end
				endcase
			end
			if (rvalid_ff && s_rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	alert_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ce && (present != present_ff || adapter_present != adapter_ff)
		|=> alert_oe)
		else $error("presence change did not assert alert");

	alert_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ce && (ara_addr_sent || host_status_read) && !alert_set
		|=> !alert_oe)
		else $error("alert not released after response or status read");

	wake_single_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		wake_en != 2'h3 &&
		(!wake_en[1] || !$past(wake_ok[0]) || !$past(ce)))
		else $error("two batteries wake charging or battery two ahead");

	wake_priority_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		wake_en != 2'h0 |-> ctrl_en == 2'h0)
		else $error("controlled charge during wake-up charge");

	wake_current_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ce && wake_ok[0] |=> wake_en == 2'h1 && low_current_mode &&
		prog_current == $past(wake_cur_ff))
		else $error("wake charge current or mode wrong");

	stop_all_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ce && ctrl_en != 2'h0 && (ctrl_en & ~ctrl_ok) != 2'h0
		|=> ctrl_en == 2'h0 && (prog_current == 16'h0000 || low_current_mode))
		else $error("charging not stopped for all batteries");

	poll_period_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		poll_req |-> poll_cnt_ff == 25'h0000000 && $past(poll_tick))
		else $error("poll request off its interval");

	restart_wake_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ce && restart_ff && !(poll_rsp[0].done || poll_rsp[1].done)
		|=> wake_need_ff == 2'h3 && alarm_ff == 2'h0)
		else $error("restart did not retry wake-up or clear alarms");

endmodule : dbcs_sequencer

// ==== inc/dbcs_pkg.sv ====
// Constants and types for the dual battery charge sequencer
// What this block does
// - Pull the host alert low on battery or adapter presence change or power-on.
// - Release alert on alert response or host status, control, info, vendor reads.
// - Alert response returns address 0x14; release alert only once it is sent.
// - Wake-up charge needs good band, adapter, no inhibit bit, no hardware inhibit.
// - Start wake-up charge when a newly inserted battery answers no reads.
// - Only one battery wake-charges; battery one first, two after one ends.
// - Wake-up charging takes priority over controlled charging.
// - Host restart or power-on clears wake timers and retries both batteries.
// - Retry wake-up on idle battery in ideal band that answers no query.
// - Disable wake-up when cold or under band beyond the charge time limit.
// - End wake-up on over band, adapter loss, calibrate, answers, alarm, inhibits.
// - End wake-up on hot, timed cold/under, stuck bus, supply fault, emergency.
// - Cache one alarm bit per battery from upper four alarm bits; keep if unanswered.
// - Clear cached alarm on removal, clean alarm read, power-on, or host restart.
// - Wake-up current fixed at wake current, low current mode, no voltage ceiling.
// - Controlled charge needs wake conditions plus clean alarm and nonzero requests.
// - Poll each battery once per poll interval for alarm, voltages and currents.
// - End controlled charge on removal, adapter loss, calibrate, zero requests, inhibits.
// - End controlled charge on read timeout, hot, stuck bus, supply fault, emergency.
// - Any stop halts all charging and zeroes the current algorithm until conditions hold.
// - Single battery: adjust programmed current by request minus report once per poll.
// - Two batteries: change total current by the smaller of both differences.
// - Never let either battery's reported current exceed its request.
package dbcs_pkg;

	localparam int             DBCS_CLK_NS        = 50;
	localparam int             DBCS_POLL_NS       = 1000000000;
	localparam logic [24:0]    DBCS_POLL_CYCLES   =
		25'(DBCS_POLL_NS / DBCS_CLK_NS);
	localparam int             DBCS_LIMIT_S       = 180;
	localparam logic [7:0]     DBCS_LIMIT_POLLS   =
		8'(DBCS_LIMIT_S * 1000 / (DBCS_POLL_NS / 1000000));

	localparam logic [7:0]     DBCS_ARA_ADDR      = 8'h14;

	localparam logic [3:0]     DBCS_OFF_CTRL      = 4'h0;
	localparam logic [3:0]     DBCS_OFF_STATUS    = 4'h4;
	localparam logic [3:0]     DBCS_OFF_PROG      = 4'h8;
	localparam logic [3:0]     DBCS_OFF_WAKE_CUR  = 4'hC;

	localparam int             DBCS_CTRL_INHIBIT  = 0;
	localparam int             DBCS_CTRL_CALIB    = 1;
	localparam int             DBCS_CTRL_PNG      = 2;
	localparam int             DBCS_CTRL_RESTART  = 3;
	localparam logic [2:0]     DBCS_CTRL_RST      = 3'h0;
	localparam logic [15:0]    DBCS_WAKE_CUR_RST  = 16'h0080;
	localparam logic [1:0]     DBCS_RESP_OKAY     = 2'h0;
	localparam logic [1:0]     DBCS_RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		BAND_COLD,
		BAND_IDEAL,
		BAND_UNDER,
		BAND_OVER,
		BAND_HOT
	} dbcs_band_t;

	// One finished poll of one battery, from the bus master engine
	typedef struct packed {
		logic        done;
		logic        alarm_ack;
		logic [15:0] alarm;
		logic        rcur_ack;
		logic [15:0] rcur;
		logic        cur_ack;
		logic [15:0] cur;
		logic        rvol_ack;
		logic [15:0] rvol;
		logic        vol_ack;
	} dbcs_poll_t;

endpackage : dbcs_pkg

// ==== test/dbcs_batt_model.sv ====
// Two smart batteries answering each poll, battery one first
`timescale 1ns/1ps
module dbcs_batt_model
	import dbcs_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             poll_req,
	input  wire logic [1:0]       answer,
	input  wire logic [1:0][15:0] alarm,
	input  wire logic [1:0][15:0] rcur,
	input  wire logic [1:0][15:0] cur,
	input  wire logic [1:0][15:0] rvol,
	output dbcs_poll_t [1:0]      poll_rsp
);
	logic [3:0] cnt_ff;
	// Restarted by every poll; battery one ends at 4, battery two at 8
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			cnt_ff <= 4'h0;
		else if (poll_req)
			cnt_ff <= 4'h1;
		else if (cnt_ff != 4'h0)
			cnt_ff <= cnt_ff + 4'h1;
	end
	// A silent battery leaves the words floating, so they show inverted
	always_comb begin
		for (int b = 0; b < 2; b++) begin
			poll_rsp[b].done = cnt_ff == 4'(4 * b + 4);
			poll_rsp[b].alarm_ack = answer[b];
			poll_rsp[b].rcur_ack = answer[b];
			poll_rsp[b].cur_ack = answer[b];
			poll_rsp[b].rvol_ack = answer[b];
			poll_rsp[b].vol_ack = answer[b];
			poll_rsp[b].alarm = answer[b] ? alarm[b] : ~alarm[b];
			poll_rsp[b].rcur = answer[b] ? rcur[b] : ~rcur[b];
			poll_rsp[b].cur = answer[b] ? cur[b] : ~cur[b];
			poll_rsp[b].rvol = answer[b] ? rvol[b] : ~rvol[b];
		end
	end
endmodule : dbcs_batt_model

// ==== test/dbcs_sequencer_tb.sv ====
// Bench for the charge sequencer: register tasks and charging scenarios
`timescale 1ns/1ps
module dbcs_sequencer_tb;
	import dbcs_pkg::*;
	logic             sys_clk = 1'b0, reset_n = 1'b0, ce = 1'b1;
	logic             s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic             s_arvalid = 1'b0, s_rready = 1'b0;
	logic [3:0]       s_awaddr = 4'h0, s_araddr = 4'h0;
	logic [31:0]      s_wdata = 32'h0, s_rdata, d, p0;
	logic [1:0]       s_bresp, s_rresp, wake_en, ctrl_en, answer = 2'h0;
	logic             s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic             adapter_present = 1'b0, adapter_divider_input = 1'b1;
	logic             mode_pin_low = 1'b0, bus_supply_sense = 1'b0;
	logic [2:0]       bus_line_low = 3'h0;
	logic             ara_addr_sent = 1'b0, host_status_read = 1'b0;
	logic             poll_req, low_current_mode, vceil_bypass, alert_oe;
	logic [7:0]       ara_address;
	logic [15:0]      prog_current;
	logic [1:0][15:0] alarm = '0, cur = {16'h02BC, 16'h02BC};
	logic [1:0][15:0] rcur = {16'h0320, 16'h03E8}, rvol = {2{16'h2EE0}};
	dbcs_band_t [1:0] band = '{BAND_OVER, BAND_OVER};
	dbcs_poll_t [1:0] poll_rsp;
	int               num_errors = 0, tests_run = 0;

	always #25 sys_clk = ~sys_clk;

	dbcs_sequencer #(.POLL_CYCLES(25'h32), .LIMIT_POLLS(8'h4)) i_dbcs_sequencer (
		.sys_clk, .reset_n, .ce, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready, .band, .poll_rsp, .adapter_present,
		.adapter_divider_input, .mode_pin_low, .bus_supply_sense,
		.bus_line_low, .ara_addr_sent, .host_status_read, .poll_req,
		.wake_en, .ctrl_en, .prog_current, .low_current_mode, .vceil_bypass,
		.alert_oe, .ara_address);

	dbcs_batt_model i_dbcs_batt_model (.sys_clk, .reset_n, .poll_req,
		.answer, .alarm, .rcur, .cur, .rvol, .poll_rsp);

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic lim(input int n);
		if (n >= 200) begin
			num_errors++;
			give_verdict();
		end
	endtask : lim

	task automatic cy(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : cy

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		int n;
		n = 0;
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1 && n < 200);
		s_bready <= 1'b0;
		chk(s_bresp, DBCS_RESP_OKAY);
		lim(n);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		int n;
		n = 0;
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_arready) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1 && n < 200);
		s_rready <= 1'b0;
		v = s_rdata;
		chk(s_rresp, DBCS_RESP_OKAY);
		lim(n);
	endtask : rd

	// Waits for k poll ticks, then lets both answers and decisions settle
	task automatic tick(input int k);
		int n;
		repeat (k) begin
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (poll_req !== 1'b1 && n < 200);
			lim(n);
		end
		cy(12);
	endtask : tick

	task automatic cause(input int i, input logic on);
		case (i)
			0, 1, 2: wr(DBCS_OFF_CTRL, 32'(on) << i);
			3: begin
				mode_pin_low <= on;
				bus_supply_sense <= on;
			end
			4: adapter_divider_input <= !on;
			5: adapter_present <= !on;
			6: band[0] <= on ? BAND_HOT : BAND_IDEAL;
			default: bus_line_low <= {2'h0, on};
		endcase
	endtask : cause

	initial begin
		cy(16);
		reset_n <= 1'b1;
		cy(1);
		chk(alert_oe, 1);
		chk(ara_address, 8'h14);
		rd(DBCS_OFF_WAKE_CUR, d);
		chk(d, 32'(DBCS_WAKE_CUR_RST));
		host_status_read <= 1'b1;
		cy(1);
		host_status_read <= 1'b0;
		cy(2);
		chk(alert_oe, 0);
		adapter_present <= 1'b1;
		band <= '{BAND_IDEAL, BAND_IDEAL};
		cy(3);
		chk(alert_oe, 1);
		ara_addr_sent <= 1'b1;
		cy(1);
		ara_addr_sent <= 1'b0;
		cy(2);
		chk(alert_oe, 0);
		tick(1);
		chk(wake_en, 2'h1);
		chk({low_current_mode, vceil_bypass}, 2'h3);
		wr(DBCS_OFF_CTRL, 32'h1);
		cy(3);
		chk(wake_en, 2'h0);
		wr(DBCS_OFF_CTRL, 32'h0);
		cy(3);
		chk(wake_en, 2'h1);
		answer <= 2'h1;
		tick(1);
		chk(wake_en, 2'h2);
		chk(ctrl_en, 2'h0);
		answer <= 2'h3;
		tick(3);
		chk(wake_en, 2'h0);
		chk(ctrl_en, 2'h3);
		tick(1);
		p0 = 32'(prog_current);
		tick(1);
		chk(16'(prog_current - p0[15:0]), 16'h0064);
		for (int i = 0; i < 8; i++) begin
			cause(i, 1'b1);
			// A stuck bus needs a full interval; the rest are looked at
			// before the next poll lets the healthy battery resume alone
			cy(i == 7 ? 60 : 3);
			chk(ctrl_en, 2'h0);
			chk(prog_current, 16'h0000);
			cause(i, 1'b0);
			tick(3);
			chk(ctrl_en, 2'h3);
		end
		band[1] <= BAND_OVER;
		cy(3);
		chk(ctrl_en, 2'h0);
		tick(3);
		chk(ctrl_en, 2'h1);
		p0 = 32'(prog_current);
		tick(1);
		chk(16'(prog_current - p0[15:0]), 16'h012C);
		// Clock enable low must freeze the servo across a whole poll interval
		p0 = 32'(prog_current);
		ce <= 1'b0;
		cy(60);
		chk(prog_current, p0[15:0]);
		ce <= 1'b1;
		alarm[0] <= 16'h2000;
		tick(1);
		chk(ctrl_en, 2'h0);
		answer <= 2'h0;
		tick(1);
		rd(DBCS_OFF_STATUS, d);
		chk(d[7:6], 2'h1);
		chk(d[4], 1'b1);
		chk(wake_en, 2'h0);
		alarm[0] <= 16'h0000;
		answer <= 2'h1;
		tick(1);
		rd(DBCS_OFF_STATUS, d);
		chk(d[7:6], 2'h0);
		tick(2);
		chk(ctrl_en, 2'h1);
		answer <= 2'h0;
		tick(8);
		chk(ctrl_en, 2'h0);
		chk(wake_en, 2'h1);
		band[0] <= BAND_COLD;
		tick(7);
		chk(wake_en, 2'h0);
		wr(DBCS_OFF_CTRL, 32'h8);
		tick(1);
		chk(wake_en, 2'h1);
		give_verdict();
	end
endmodule : dbcs_sequencer_tb
